/* File: include/uit_pkg.sv */
package uit_pkg;
    // =========================================================
    // Data path sizes.
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int COUNT_W = 5;

    // =========================================================
    // Receive timeout, counted in ticks of the sixteen-times baud clock.
    localparam int TIMEOUT_TICKS = 511;
    localparam int TIMER_W = 9;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 9'h000;

    // =========================================================
    // Positions of the request flags in the flag vector.
    localparam int IRQ_OVERRUN = 0;
    localparam int IRQ_BREAK = 1;
    localparam int IRQ_PARITY = 2;
    localparam int IRQ_FRAMING = 3;
    localparam int IRQ_TIMEOUT = 4;
    localparam int IRQ_TX = 5;
    localparam int IRQ_RX = 6;
    localparam int IRQ_COUNT = 7;
    localparam logic [IRQ_COUNT-1:0] FLAGS_RESET = 7'h00;
endpackage

/* File: verilog/uit_fifo.sv */
`timescale 1ns/1ps
module uit_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = 5
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    input wire logic out_ready_in,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    // Fill level
    output logic [CW-1:0] count_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    // =========================================================
    // Handshakes; full and empty follow the true fill level.
    assign in_ready_out = (count != CW'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign count_out = count;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointers wrap at the depth, which need not be a power of two.
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage carries no reset, so it maps onto plain memory.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule

/* File: verilog/uit_irq_timing.sv */
// Behaviour
// [RULE1] Stop bit received while receive buffer full raises the overrun request.
// [RULE2] Break request rises when the stop bit position of a break frame arrives.
// [RULE3] Parity request rises once a wrong parity bit has been received.
// [RULE4] Framing request rises once the bit breaking the frame end is received.
// [RULE5] Receive timeout rises 511 baud ticks after the last store into the buffer.
// [RULE6] Without transmit FIFO, writing the next word clears the transmit request.
// [RULE7] With transmit FIFO, stop bit start at trigger fill level raises transmit request.
// [RULE8] Without receive FIFO, every received stop bit raises the receive request.
// [RULE9] With receive FIFO, the stop bit reaching the trigger level raises receive request.
// [RULE10] Without transmit FIFO, moving the held word into the shifter raises transmit request.
// [RULE11] Software may clear the transmit request through its clear bit.
// [RULE12] Each request stays set from its event until its clearing condition.
`timescale 1ns/1ps
module uit_irq_timing (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Sixteen-times baud tick, one cycle wide
    input wire logic baud_x16_clock_in,
    // Configuration
    input wire logic tx_fifo_enable_in,
    input wire logic rx_fifo_enable_in,
    input wire logic [uit_pkg::COUNT_W-1:0] tx_trigger_level_in,
    input wire logic [uit_pkg::COUNT_W-1:0] rx_trigger_level_in,
    // Receiver frame events
    input wire logic rx_stop_in,
    input wire logic rx_break_in,
    input wire logic [uit_pkg::DATA_W-1:0] rx_frame_data_in,
    input wire logic rx_parity_done_in,
    input wire logic rx_parity_bad_in,
    input wire logic rx_frame_bad_in,
    // Receive data towards software
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [uit_pkg::DATA_W-1:0] rx_data_out,
    // Transmit data from software
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [uit_pkg::DATA_W-1:0] tx_data_in,
    // Transmit shift register side
    output logic tx_shift_valid_out,
    input wire logic tx_shift_ready_in,
    output logic [uit_pkg::DATA_W-1:0] tx_shift_data_out,
    input wire logic tx_stop_start_in,
    // Request flags and software clears, one bit per source
    input wire logic [uit_pkg::IRQ_COUNT-1:0] irq_clear_in,
    output logic [uit_pkg::IRQ_COUNT-1:0] irq_flags_out
);
    logic [uit_pkg::COUNT_W-1:0] tx_count;
    logic [uit_pkg::COUNT_W-1:0] rx_count;
    logic tx_fifo_in_valid;
    logic tx_fifo_in_ready;
    logic tx_push;
    logic tx_pop;
    logic rx_fifo_in_ready;
    logic rx_full;
    logic rx_push;
    logic rx_level_hit;
    logic tmo_fire;
    logic [uit_pkg::IRQ_COUNT-1:0] flags;
    logic [uit_pkg::IRQ_COUNT-1:0] next_flags;
    logic [uit_pkg::IRQ_COUNT-1:0] set_vec;
    logic [uit_pkg::IRQ_COUNT-1:0] clr_vec;
    logic [uit_pkg::TIMER_W-1:0] tmo_cnt;
    logic [uit_pkg::TIMER_W-1:0] next_tmo_cnt;
    logic tmo_armed;
    logic next_tmo_armed;

    // =========================================================
    // Transmit path
    // With the FIFO off only one word may wait, which models the holding buffer.
    assign tx_fifo_in_valid = tx_valid_in && (tx_fifo_enable_in || (tx_count == '0));
    assign tx_ready_out = tx_fifo_in_ready && (tx_fifo_enable_in || (tx_count == '0));
    assign tx_push = tx_valid_in && tx_ready_out;
    assign tx_pop = tx_shift_valid_out && tx_shift_ready_in;

    uit_fifo #(
        .WIDTH(uit_pkg::DATA_W),
        .DEPTH(uit_pkg::FIFO_DEPTH),
        .CW(uit_pkg::COUNT_W)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(tx_fifo_in_valid),
        .in_ready_out(tx_fifo_in_ready),
        .in_data_in(tx_data_in),
        .out_ready_in(tx_shift_ready_in),
        .out_valid_out(tx_shift_valid_out),
        .out_data_out(tx_shift_data_out),
        .count_out(tx_count)
    );

    // =========================================================
    // Receive path
    // A frame that finds the buffer full is dropped; software stalls the drain.
    assign rx_full = !rx_fifo_in_ready || (!rx_fifo_enable_in && (rx_count != '0));
    assign rx_push = rx_stop_in && !rx_full;
    assign rx_level_hit = rx_push && ((rx_count + 1'b1) == rx_trigger_level_in);

    uit_fifo #(
        .WIDTH(uit_pkg::DATA_W),
        .DEPTH(uit_pkg::FIFO_DEPTH),
        .CW(uit_pkg::COUNT_W)
    ) u_rx_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(rx_push),
        .in_ready_out(rx_fifo_in_ready),
        .in_data_in(rx_frame_data_in),
        .out_ready_in(rx_ready_in),
        .out_valid_out(rx_valid_out),
        .out_data_out(rx_data_out),
        .count_out(rx_count)
    );

    // =========================================================
    // Receive timeout timer
    // Each store restarts the wait; an empty buffer disarms it, so no stale timeout.
    assign tmo_fire = tmo_armed && baud_x16_clock_in &&
        (tmo_cnt == uit_pkg::TIMER_W'(uit_pkg::TIMEOUT_TICKS - 1)); // see [RULE5]

    always_comb begin
        next_tmo_cnt = tmo_cnt;
        next_tmo_armed = tmo_armed;
        if (rx_push) begin
            next_tmo_cnt = uit_pkg::TIMER_RESET; // see [RULE5]
            next_tmo_armed = 1'b1;
        end else if (!rx_valid_out || tmo_fire) begin
            next_tmo_cnt = uit_pkg::TIMER_RESET;
            next_tmo_armed = 1'b0;
        end else if (tmo_armed && baud_x16_clock_in) begin
            next_tmo_cnt = tmo_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tmo_cnt <= uit_pkg::TIMER_RESET;
            tmo_armed <= 1'b0;
        end else begin
            tmo_cnt <= next_tmo_cnt;
            tmo_armed <= next_tmo_armed;
        end
    end

    // =========================================================
    // Request flags
    // Set wins over clear, so an event in the clearing cycle is never lost.
    always_comb begin
        set_vec = '0;
        clr_vec = irq_clear_in; // see [RULE11]
        set_vec[uit_pkg::IRQ_OVERRUN] = rx_stop_in && rx_full; // see [RULE1]
        set_vec[uit_pkg::IRQ_BREAK] = rx_stop_in && rx_break_in; // see [RULE2]
        set_vec[uit_pkg::IRQ_PARITY] = rx_parity_done_in && rx_parity_bad_in; // see [RULE3]
        set_vec[uit_pkg::IRQ_FRAMING] = rx_frame_bad_in; // see [RULE4]
        set_vec[uit_pkg::IRQ_TIMEOUT] = tmo_fire; // see [RULE5]
        if (tx_fifo_enable_in) begin
            set_vec[uit_pkg::IRQ_TX] = tx_stop_start_in &&
                (tx_count == tx_trigger_level_in); // see [RULE7]
            if (tx_count > tx_trigger_level_in) begin
                clr_vec[uit_pkg::IRQ_TX] = 1'b1;
            end
        end else begin
            set_vec[uit_pkg::IRQ_TX] = tx_pop; // see [RULE10]
            if (tx_push) begin
                clr_vec[uit_pkg::IRQ_TX] = 1'b1; // see [RULE6]
            end
        end
        if (rx_fifo_enable_in) begin
            set_vec[uit_pkg::IRQ_RX] = rx_level_hit; // see [RULE9]
        end else begin
            set_vec[uit_pkg::IRQ_RX] = rx_stop_in; // see [RULE8]
        end
        next_flags = set_vec | (flags & ~clr_vec); // see [RULE12]
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags <= uit_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    assign irq_flags_out = flags;

    // =========================================================
    // Checks
    sequence s_stop_full;
        rx_stop_in && rx_full;
    endsequence

    sequence s_tx_store_plain;
        !tx_fifo_enable_in && tx_push && !tx_pop;
    endsequence

    a_overrun_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE1]
        s_stop_full |=> irq_flags_out[uit_pkg::IRQ_OVERRUN])
        else $error("Overrun request missing after stop bit into a full buffer.");

    a_break_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE2]
        rx_stop_in && rx_break_in |=> irq_flags_out[uit_pkg::IRQ_BREAK])
        else $error("Break request missing after break stop position.");

    a_parity_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE3]
        rx_parity_done_in && rx_parity_bad_in |=> irq_flags_out[uit_pkg::IRQ_PARITY])
        else $error("Parity request missing after a bad parity bit.");

    a_framing_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE4]
        rx_frame_bad_in |=> irq_flags_out[uit_pkg::IRQ_FRAMING])
        else $error("Framing request missing after a bad frame end.");

    a_timeout_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE5]
        tmo_armed && baud_x16_clock_in && !rx_push && rx_valid_out &&
        tmo_cnt == uit_pkg::TIMER_W'(uit_pkg::TIMEOUT_TICKS - 1)
        |=> irq_flags_out[uit_pkg::IRQ_TIMEOUT] && !tmo_armed)
        else $error("Receive timeout did not fire on the last baud tick.");

    a_tx_auto_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE6]
        s_tx_store_plain ##1 !tx_pop && !tx_push |-> !irq_flags_out[uit_pkg::IRQ_TX])
        else $error("Transmit request not cleared by a data write.");

    a_tx_level_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE7]
        tx_fifo_enable_in && tx_stop_start_in && tx_count == tx_trigger_level_in
        |=> irq_flags_out[uit_pkg::IRQ_TX])
        else $error("Transmit request missing at trigger level.");

    a_rx_stop_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE8]
        !rx_fifo_enable_in && rx_stop_in |=> irq_flags_out[uit_pkg::IRQ_RX])
        else $error("Receive request missing after a stop bit.");

    // A drain in the storing cycle leaves the fill level where it was.
    a_rx_level_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE9]
        rx_fifo_enable_in && rx_push && rx_count + 1'b1 == rx_trigger_level_in
        |=> irq_flags_out[uit_pkg::IRQ_RX] &&
        rx_count == $past(rx_count) + 1'b1 - $past(rx_valid_out && rx_ready_in))
        else $error("Receive request missing at trigger level.");

    a_tx_move_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE10]
        !tx_fifo_enable_in && tx_pop
        |=> irq_flags_out[uit_pkg::IRQ_TX] && !tx_shift_valid_out)
        else $error("Transmit request missing after buffer emptied.");

    a_tx_sw_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE11]
        irq_clear_in[uit_pkg::IRQ_TX] && !set_vec[uit_pkg::IRQ_TX]
        |=> !irq_flags_out[uit_pkg::IRQ_TX])
        else $error("Software clear of transmit request ignored.");

    a_flag_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in) // see [RULE12]
        irq_flags_out[uit_pkg::IRQ_PARITY] && !irq_clear_in[uit_pkg::IRQ_PARITY]
        |=> $stable(irq_flags_out[uit_pkg::IRQ_PARITY]))
        else $error("Parity request dropped without a clear.");
endmodule

/* File: dv/uit_peer.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-side peer: ends receive frames and takes words for the line.
module uit_peer (
    // Clock and stall control
    input wire logic clk_in,
    input wire logic hold_in,
    // Transmit shifter side
    input wire logic tx_shift_valid_in,
    input wire logic [uit_pkg::DATA_W-1:0] tx_shift_data_in,
    output logic tx_shift_ready_out,
    output logic tx_stop_start_out,
    // Receiver side
    output logic rx_stop_out,
    output logic rx_break_out,
    output logic [uit_pkg::DATA_W-1:0] rx_frame_data_out
);
    logic [uit_pkg::DATA_W-1:0] got[$];

    // Idle levels at time zero.
    initial begin
        tx_stop_start_out = 1'b0;
        rx_stop_out = 1'b0;
        rx_break_out = 1'b0;
        rx_frame_data_out = 8'h00;
    end

    // The shifter stalls on command, so the buffer in front can fill up.
    assign tx_shift_ready_out = ~hold_in;

    // Every word taken is kept for later comparison.
    always @(posedge clk_in) begin
        if (tx_shift_valid_in && tx_shift_ready_out) begin
            got.push_back(tx_shift_data_in);
        end
    end

    // Ends one frame; the data lines then show the inverse so stale data is never trusted.
    task automatic frame(input logic [uit_pkg::DATA_W-1:0] d, input logic brk);
        @(posedge clk_in);
        rx_stop_out <= 1'b1;
        rx_break_out <= brk;
        rx_frame_data_out <= d;
        @(posedge clk_in);
        rx_stop_out <= 1'b0;
        rx_break_out <= 1'b0;
        rx_frame_data_out <= ~d;
    endtask

    // Marks the start of one transmitted stop bit.
    task automatic stop_bit();
        @(posedge clk_in);
        tx_stop_start_out <= 1'b1;
        @(posedge clk_in);
        tx_stop_start_out <= 1'b0;
    endtask
endmodule

/* File: dv/uart_interrupt_timing_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the request flag timing.
module uart_interrupt_timing_test;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic tick = 1'b0, txf = 1'b0, rxf = 1'b0, hold = 1'b1;
    logic p_done = 1'b0, p_bad = 1'b0, f_bad = 1'b0, rx_ready = 1'b0, tx_valid = 1'b0;
    logic [4:0] txl = 5'h00, rxl = 5'h00;
    logic [7:0] tx_data = 8'h00, d;
    logic [6:0] clr = 7'h00;
    logic rx_stop, rx_brk, rx_valid, tx_ready, sh_valid, sh_ready, stop_start;
    logic [7:0] rx_d, rx_data, sh_data;
    logic [6:0] flags;
    logic [15:0] seed = 16'hfdc1;
    logic [7:0] q[$];
    int n_mismatch = 0, n_checks = 0, lvl;

    // Clock of 100 ns period.
    always #50 clk_in = ~clk_in;

    uit_irq_timing uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .baud_x16_clock_in(tick),
        .tx_fifo_enable_in(txf), .rx_fifo_enable_in(rxf), .tx_trigger_level_in(txl),
        .rx_trigger_level_in(rxl), .rx_stop_in(rx_stop), .rx_break_in(rx_brk),
        .rx_frame_data_in(rx_d), .rx_parity_done_in(p_done), .rx_parity_bad_in(p_bad),
        .rx_frame_bad_in(f_bad), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
        .rx_data_out(rx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .tx_data_in(tx_data), .tx_shift_valid_out(sh_valid), .tx_shift_ready_in(sh_ready),
        .tx_shift_data_out(sh_data), .tx_stop_start_in(stop_start), .irq_clear_in(clr),
        .irq_flags_out(flags));

    uit_peer peer (.clk_in(clk_in), .hold_in(hold), .tx_shift_valid_in(sh_valid),
        .tx_shift_data_in(sh_data), .tx_shift_ready_out(sh_ready),
        .tx_stop_start_out(stop_start), .rx_stop_out(rx_stop), .rx_break_out(rx_brk),
        .rx_frame_data_out(rx_d));

    // ==========================================================
    // Expectations and helpers
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction

    // The receive request stays up once the fill level has reached the trigger.
    function automatic logic rx_due(input int n, input int level);
        return n >= level;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic clear(input logic [6:0] m);
        @(posedge clk_in);
        clr <= m;
        @(posedge clk_in);
        clr <= 7'h00;
        #1;
    endtask

    // Holds the write until the edge at which ready is seen high.
    task automatic wr(input logic [7:0] v);
        @(posedge clk_in);
        tx_valid <= 1'b1;
        tx_data <= v;
        for (int k = 0; k < 50; k++) begin
            @(negedge clk_in);
            if (tx_ready) break;
        end
        @(posedge clk_in);
        tx_valid <= 1'b0;
        #1;
    endtask

    task automatic pop(input logic [7:0] exp);
        for (int k = 0; k < 50 && rx_valid !== 1'b1; k++) @(negedge clk_in);
        chk(rx_data, exp);
        @(posedge clk_in);
        rx_ready <= 1'b1;
        @(posedge clk_in);
        rx_ready <= 1'b0;
        #1;
    endtask

    // Lets the peer take words until it has n in total.
    task automatic drain(input int n);
        @(posedge clk_in);
        hold <= 1'b0;
        for (int k = 0; k < 200 && peer.got.size() < n; k++) @(negedge clk_in);
        @(posedge clk_in);
        hold <= 1'b1;
        #1;
        chk(peer.got.size(), n);
    endtask

    task automatic ticks(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk_in);
            tick <= 1'b1;
            @(posedge clk_in);
            tick <= 1'b0;
        end
        #1;
    endtask

    // A hang is cut short well past the expected run length.
    initial begin
        #2000000;
        n_mismatch++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk({flags, tx_ready, rx_valid}, 9'h002);
        @(posedge clk_in);
        f_bad <= 1'b1;
        @(posedge clk_in);
        f_bad <= 1'b0;
        #1;
        chk(flags[3], 1'b1);
        repeat (3) @(posedge clk_in);
        #1;
        chk(flags[3], 1'b1);
        clear(7'h08);
        chk(flags, 7'h00);
        // An event in the very cycle of its clear must win, or it would be lost.
        @(posedge clk_in);
        f_bad <= 1'b1;
        clr <= 7'h08;
        @(posedge clk_in);
        f_bad <= 1'b0;
        clr <= 7'h00;
        #1;
        chk(flags[3], 1'b1);
        // A good parity bit must not raise the request, a bad one must.
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_in);
            p_done <= 1'b1;
            p_bad <= b[0];
            @(posedge clk_in);
            p_done <= 1'b0;
            #1;
            chk(flags[2], b[0]);
        end
        clear(7'h7f);
        // One-word receive buffer: a second frame finds it full.
        d = rnd();
        peer.frame(d, 1'b1);
        #1;
        chk(flags, 7'h42);
        clear(7'h42);
        peer.frame(~d, 1'b0);
        #1;
        chk(flags, 7'h41);
        pop(d);
        clear(7'h7f);
        // Receive FIFO up to full and one frame beyond.
        lvl = rnd() % 15 + 1;
        @(posedge clk_in);
        rxf <= 1'b1;
        rxl <= lvl[4:0];
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            q.push_back(d);
            peer.frame(d, 1'b0);
            #1;
            chk(flags[6], rx_due(i + 1, lvl));
        end
        peer.frame(rnd(), 1'b0);
        #1;
        chk(flags[0], 1'b1);
        clear(7'h7f);
        ticks(510);
        chk(flags[4], 1'b0);
        ticks(1);
        @(posedge clk_in);
        #1;
        chk(flags[4], 1'b1);
        while (q.size() > 0) pop(q.pop_front());
        chk(rx_valid, 1'b0);
        clear(7'h7f);
        // One-word transmit buffer.
        d = rnd();
        wr(d);
        chk({tx_ready, flags[5]}, 2'b00);
        drain(1);
        chk(flags[5], 1'b1);
        wr(~d);
        chk(flags[5], 1'b0);
        drain(2);
        chk(flags[5], 1'b1);
        clear(7'h20);
        chk(flags[5], 1'b0);
        chk({peer.got[0], peer.got[1]}, {d, ~d});
        // Transmit FIFO against its trigger level, filled until refused.
        lvl = rnd() % 15 + 1;
        @(posedge clk_in);
        txf <= 1'b1;
        txl <= lvl[4:0];
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            q.push_back(d);
            wr(d);
            if (i + 1 == lvl) begin
                peer.stop_bit();
                #1;
                chk(flags[5], 1'b1);
            end
        end
        chk({tx_ready, flags[5]}, 2'b00);
        peer.stop_bit();
        #1;
        chk(flags[5], 1'b0);
        drain(18);
        foreach (q[i]) chk(peer.got[i + 2], q[i]);
        conclude();
    end
endmodule
